// [ebw_bus_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none

module ebw_bus_ctrl
  import ebw_pkg::*;
(
  input  wire logic                    clk_i,                 // Bus clock
  input  wire logic                    rst_i,                 // Sync reset, high
  input  wire logic                    ce_i,                  // Clock enable
  input  wire logic [1:0]              proc_mode_i,           // Processor mode
  input  wire logic                    global_wait_select_i,  // Wait on every area
  input  wire logic [AREAS-1:0]        area_wait_select_i,    // Per-area wait
  input  wire logic                    req_valid_i,           // Access request
  input  wire ebw_pkg::ebw_req_s       req_i,                 // Access fields
  output logic                         req_ready_o,           // Request taken
  output logic                         done_o,                // Access finished
  output logic [DATA_W-1:0]            rdata_o,               // Read data
  input  wire logic                    ready_n_i,             // External ready
  input  wire logic                    hold_request_n_i,      // External hold
  input  wire logic [DATA_W-1:0]       data_i,                // Data pins in
  output ebw_pkg::ebw_pins_s           pins_o,                // Bus pins out
  output logic                         bus_oe_o,              // Pin drive enable
  output logic                         data_oe_o,             // Data drive enable
  output logic                         ale_o,                 // Address latch enable
  output logic                         hold_acknowledge_n_o   // Hold acknowledge
);
  import ebw_pkg::*;

  typedef struct packed {
    ebw_state_e        state;
    logic [1:0]        rdy_sync;
    logic [1:0]        hold_sync;
    logic [1:0]        left;
    logic              waited;
    logic              write;
    logic              req_ready;
    logic              done;
    logic [DATA_W-1:0] rdata;
    ebw_pins_s         pins;
    logic              bus_oe;
    logic              data_oe;
    logic              ale;
    logic              hold_acknowledge_n_n;
  } ebw_st_s;

  ebw_st_s st_reg;
  ebw_st_s st_next;

  logic rdy_n;
  logic hold_n;
  logic hold_on;
  logic use_wait;

  // Only the second sync stage is consumed
  assign rdy_n   = st_reg.rdy_sync[1];
  assign hold_n  = st_reg.hold_sync[1];
  // Hold ignored in single-chip mode
  assign hold_on = !hold_n && (proc_mode_i != MODE_SINGLE);
  // Global bit overrides per-area bits
  assign use_wait = global_wait_select_i
                    || area_wait_select_i[req_i.area];

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    st_next.rdy_sync  = {st_reg.rdy_sync[0], ready_n_i};
    st_next.hold_sync = {st_reg.hold_sync[0], hold_request_n_i};
    st_next.req_ready = 1'b0;
    st_next.done      = 1'b0;
    st_next.ale       = 1'b0;
    case (st_reg.state)
      EBW_IDLE: begin
        // Hold checked only between cycles, so a cycle is never cut
        if (hold_on) begin
          st_next.state   = EBW_FLOAT;
          st_next.bus_oe  = 1'b0;
          st_next.data_oe = 1'b0;
        end else if (req_valid_i) begin
          st_next.state     = EBW_CYCLE;
          st_next.req_ready = 1'b1;
          st_next.waited    = use_wait;
          st_next.write     = req_i.write;
          st_next.ale       = req_i.mux_area;
          if (!use_wait) begin
            st_next.left = NOWAIT_CYCLES - 2'h1;
          end else if (req_i.mux_area) begin
            st_next.left = MUX_CYCLES - 2'h1;
          end else begin
            st_next.left = SEP_CYCLES - 2'h1;
          end
          st_next.pins.addr               = req_i.addr;
          st_next.pins.data               = req_i.wdata;
          st_next.pins.rd_n               = req_i.write;
          st_next.pins.wr_n               = !req_i.write;
          st_next.pins.write_low_byte_n   = !(req_i.write && req_i.byte_en[0]);
          st_next.pins.write_high_byte_n  = !(req_i.write && req_i.byte_en[1]);
          st_next.pins.byte_high_enable_n = !req_i.byte_en[1];
          st_next.pins.area_select_n      = ~(4'h1 << req_i.area);
          st_next.data_oe                 = req_i.write;
        end
      end
      EBW_CYCLE: begin
        // Ready stretches only waited cycles, in whole clocks
        if (st_reg.left != 2'h0) begin
          st_next.left = st_reg.left - 2'h1;
        end else if (st_reg.waited && !rdy_n) begin
          st_next.left = 2'h0;
        end else begin
          st_next.state          = EBW_IDLE;
          st_next.done           = 1'b1;
          // Writes leave the last read data standing
          if (!st_reg.write) begin
            st_next.rdata        = data_i;
          end
          st_next.pins.rd_n      = 1'b1;
          st_next.pins.wr_n      = 1'b1;
          st_next.pins.write_low_byte_n  = 1'b1;
          st_next.pins.write_high_byte_n = 1'b1;
          st_next.pins.area_select_n     = '1;
          st_next.data_oe        = 1'b0;
        end
      end
      EBW_FLOAT: begin
        st_next.state  = EBW_HELD;
        st_next.hold_acknowledge_n_n = 1'b0;
      end
      EBW_HELD: begin
        // Latch enable toggles on every enabled clock while released
        st_next.ale = !st_reg.ale;
        if (!hold_on) begin
          st_next.state  = EBW_UNACK;
          st_next.hold_acknowledge_n_n = 1'b1;
        end
      end
      EBW_UNACK: begin
        // Restore prior pin values one clock after acknowledge rises
        st_next.state  = EBW_IDLE;
        st_next.bus_oe = 1'b1;
      end
      default: st_next.state = EBW_IDLE;
    endcase
  end

  // State register, frozen while clock enable is low and reset is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg           <= '0;
      st_reg.state     <= EBW_IDLE;
      st_reg.rdy_sync  <= 2'h3;
      st_reg.hold_sync <= 2'h3;
      st_reg.pins      <= PINS_IDLE;
      st_reg.bus_oe    <= 1'b1;
      st_reg.hold_acknowledge_n_n    <= 1'b1;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign req_ready_o          = st_reg.req_ready;
  assign done_o               = st_reg.done;
  assign rdata_o              = st_reg.rdata;
  assign pins_o               = st_reg.pins;
  assign bus_oe_o             = st_reg.bus_oe;
  assign data_oe_o            = st_reg.data_oe;
  assign ale_o                = st_reg.ale;
  assign hold_acknowledge_n_o = st_reg.hold_acknowledge_n_n;

endmodule : ebw_bus_ctrl

`default_nettype wire

// [ebw_pkg.sv]
// What this block does
// - Separate bus wait: cycle lasts two clocks
// - Multiplexed bus wait: cycle lasts three clocks
// - Global wait bit forces wait everywhere
// - Otherwise per-area wait bits decide
// - Ready input honoured only with wait
// - Ready low at edge: hold bus
// - Ready high at edge: cycle continues
// - Hold request ignored in single-chip mode
// - Float bus outputs when able to release
// - Acknowledge low one clock after floating
// - Acknowledge high after request returns high
// - Drive buses again one clock later
// - Never release bus mid cycle
// - Float all twenty address lines
// - Float all sixteen data lines
// - Float read, write, byte strobes
// - Address latch enable keeps toggling
// - Float all four area selects
package ebw_pkg;

  localparam int          ADDR_W         = 20;
  localparam int          DATA_W         = 16;
  localparam int          AREAS          = 4;
  localparam logic [1:0]  SEP_CYCLES     = 2'h2;
  localparam logic [1:0]  MUX_CYCLES     = 2'h3;
  localparam logic [1:0]  NOWAIT_CYCLES  = 2'h1;
  localparam logic [1:0]  MODE_SINGLE    = 2'h0;
  localparam logic [1:0]  MODE_EXPAND    = 2'h1;
  localparam logic [1:0]  MODE_MICRO     = 2'h3;

  typedef enum logic [2:0] {
    EBW_IDLE,
    EBW_CYCLE,
    EBW_FLOAT,
    EBW_HELD,
    EBW_UNACK
  } ebw_state_e;

  // Access request from the core
  typedef struct packed {
    logic              write;
    logic              mux_area;
    logic [1:0]        area;
    logic [1:0]        byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebw_req_s;

  // Bus pins towards the memories
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              rd_n;
    logic              wr_n;
    logic              write_low_byte_n;
    logic              write_high_byte_n;
    logic              byte_high_enable_n;
    logic [AREAS-1:0]  area_select_n;
  } ebw_pins_s;

  localparam ebw_pins_s PINS_IDLE = '{
    addr: '0, data: '0, rd_n: 1'b1, wr_n: 1'b1, write_low_byte_n: 1'b1,
    write_high_byte_n: 1'b1, byte_high_enable_n: 1'b1, area_select_n: '1};

endpackage : ebw_pkg

// [ebw_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module ebw_monitor
  import ebw_pkg::*;
(
  input wire logic              clk_i,                 // Bus clock
  input wire logic              rst_i,                 // Sync reset, high
  input wire logic              global_wait_select_i,  // Wait everywhere
  input wire logic [AREAS-1:0]  area_wait_select_i,    // Wait per area
  input wire ebw_pkg::ebw_req_s req_i,                 // Access fields
  input wire logic              req_ready_o,           // Request taken
  input wire logic              done_o,                // Access finished
  input wire logic              ready_n_i,             // External ready
  input wire logic              bus_oe_o,              // Pin drive enable
  input wire logic              data_oe_o,             // Data drive enable
  input wire logic              ale_o,                 // Latch enable
  input wire logic              hold_acknowledge_n_o   // Hold answer
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wt; // Wait applies to the access in flight
  assign wt = global_wait_select_i | area_wait_select_i[req_i.area];
  // Taken with wait, ready high over the whole cycle
  // Separate bus decides on ready seen at the take edge, two sync stages late
  sequence s_sep;
    req_ready_o && wt && !req_i.mux_area && $past(ready_n_i) ##1 1'b1;
  endsequence
  sequence s_mux; req_ready_o && wt && req_i.mux_area && ready_n_i ##1 ready_n_i[*2]; endsequence
  chk_sep_two: assert property (s_sep |=> done_o) else $error("sep length");
  chk_mux_three: assert property (s_mux |=> done_o) else $error("mux length");
  chk_nowait_one: assert property (req_ready_o && !wt |=> done_o) else $error("ready used");
  chk_ready_stall: assert property (req_ready_o && wt && !$past(ready_n_i) |=> (!done_o)[*2])
    else $error("no stall");
  chk_float_ack: assert property ($fell(bus_oe_o) |=> $fell(hold_acknowledge_n_o))
    else $error("ack late");
  chk_drive_back: assert property ($rose(hold_acknowledge_n_o) |=> $rose(bus_oe_o))
    else $error("drive late");
  chk_held_float: assert property (!hold_acknowledge_n_o |-> !bus_oe_o && !data_oe_o)
    else $error("driven in hold");
  chk_ale_clock: assert property (!hold_acknowledge_n_o && !$past(hold_acknowledge_n_o)
    |-> ale_o != $past(ale_o)) else $error("ale still");
endmodule // ebw_monitor
bind ebw_bus_ctrl ebw_monitor u_monitor (.clk_i, .rst_i, .global_wait_select_i,
  .area_wait_select_i, .req_i, .req_ready_o, .done_o, .ready_n_i, .bus_oe_o, .data_oe_o,
  .ale_o, .hold_acknowledge_n_o);
`default_nettype wire

// [ebw_far_end.sv]
`timescale 1ns/1ns
`default_nettype none
module ebw_far_end
  import ebw_pkg::*;
(
  input  wire logic               clk_i,    // Bus clock
  input  wire ebw_pkg::ebw_pins_s pins_i,   // Device pins
  input  wire logic               bus_oe_i, // Device drives
  input  wire logic [3:0]         stall_i,  // Strobe clocks before ready
  output logic [DATA_W-1:0]       data_o,   // Data to device
  output logic                    ready_n_o // Slow device busy
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last = '0;
  logic [3:0]        cnt = '0;
  // Unread lines flip so a stale bus never looks right
  assign data_o = (bus_oe_i && !pins_i.rd_n) ? mem[pins_i.addr[3:0]] : ~last;
  assign ready_n_o = (cnt >= stall_i);
  always @(posedge clk_i) begin
    if (bus_oe_i && !pins_i.wr_n) mem[pins_i.addr[3:0]] <= pins_i.data;
    last <= data_o;
    cnt <= (pins_i.rd_n & pins_i.wr_n) ? 4'h0 : cnt + 4'h1;
  end
endmodule // ebw_far_end
`default_nettype wire

// [ext_bus_wait_ready_hold_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module ext_bus_wait_ready_hold_tb;
  import ebw_pkg::*;
  logic      clk_i, rst_i, req_valid, gw, rdy_n, hold_n, req_ready, done, bus_oe, data_oe, ack_n;
  logic [1:0] mode;
  logic [3:0] aw, stall;
  logic [15:0] rdata, din;
  ebw_req_s  req;
  ebw_pins_s pins;
  int        miscompares, tests_run, n, k;
  ebw_bus_ctrl DUT (.clk_i, .rst_i, .ce_i(1'b1), .proc_mode_i(mode), .global_wait_select_i(gw),
    .area_wait_select_i(aw), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
    .done_o(done), .rdata_o(rdata), .ready_n_i(rdy_n), .hold_request_n_i(hold_n), .data_i(din),
    .pins_o(pins), .bus_oe_o(bus_oe), .data_oe_o(data_oe), .ale_o(), .hold_acknowledge_n_o(ack_n));
  ebw_far_end u_far (.clk_i, .pins_i(pins), .bus_oe_i(bus_oe), .stall_i(stall), .data_o(din),
    .ready_n_o(rdy_n));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic complete_run(input bit hung);
    if (hung) miscompares++;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One access; n counts clocks from taken to done
  task automatic access(input logic w, m, input logic [1:0] a);
    @(posedge clk_i);
    req <= '{w, m, a, 2'h3, {18'h0_0000, a}, 16'h5A00 + 16'(a)};
    req_valid <= 1'b1;
    k = 0;
    do begin @(negedge clk_i); k++; end while (req_ready !== 1'b1 && k < 40);
    @(posedge clk_i);
    req_valid <= 1'b0;
    n = 0;
    do begin @(negedge clk_i); n++; end while (done !== 1'b1 && n < 40);
    if (k >= 40 || n >= 40) complete_run(1'b1);
  endtask
  task automatic wait_ack(input logic lvl);
    k = 0;
    do begin @(negedge clk_i); k++; end while (ack_n !== lvl && k < 30);
    if (k >= 30) complete_run(1'b1);
  endtask
  initial begin
    {rst_i, req_valid, gw, hold_n} = 4'h9;
    aw = 4'h0;
    stall = 4'h0;
    mode = MODE_EXPAND;
    req = '0;
    {miscompares, tests_run} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      access(1'b1, 1'b0, 2'(a));
      chk(16'(n), 16'h0001);
    end
    // Only the chosen area waits
    for (int a = 0; a < 4; a++) begin
      @(posedge clk_i);
      aw <= 4'h1 << a;
      access(1'b0, 1'b0, 2'(a));
      chk(16'(n), 16'h0002);
      chk(rdata, 16'h5A00 + 16'(a));
      access(1'b0, 1'b0, 2'(a + 1));
      chk(16'(n), 16'h0001);
    end
    @(posedge clk_i);
    {gw, aw} <= 5'h10;
    access(1'b0, 1'b1, 2'h2);
    chk(16'(n), 16'h0003);
    // Slow device; ready only counts with wait on
    @(posedge clk_i);
    stall <= 4'h3;
    access(1'b0, 1'b0, 2'h1);
    chk(16'(n > 2), 16'h0001);
    chk(rdata, 16'h5A01);
    @(posedge clk_i);
    gw <= 1'b0;
    access(1'b0, 1'b0, 2'h1);
    chk(16'(n), 16'h0001);
    @(posedge clk_i);
    {gw, stall} <= 5'h10;
    fork
      access(1'b0, 1'b1, 2'h3);
      begin repeat (2) @(posedge clk_i); hold_n <= 1'b0; end
    join
    chk(16'(n), 16'h0003);
    wait_ack(1'b0);
    chk(16'({bus_oe, data_oe}), 16'h0000);
    @(posedge clk_i);
    hold_n <= 1'b1;
    wait_ack(1'b1);
    @(negedge clk_i);
    chk(16'(bus_oe), 16'h0001);
    @(posedge clk_i);
    {mode, hold_n} <= {MODE_SINGLE, 1'b0};
    repeat (8) @(negedge clk_i);
    chk(16'(ack_n), 16'h0001);
    complete_run(1'b0);
  end
endmodule // ext_bus_wait_ready_hold_tb
`default_nettype wire
